// *** rtl/migs_top.sv ***
/*
  multiplexed input group slave: sixteen inputs as four groups of four,
  one group selected by the one-hot output data word of each bus exchange.
  assumes the link layer delivers one exchange strobe per bus cycle with the
  received output data, and sends back the input data held here.
  assumes the field inputs are free-running levels; a change takes about four
  clocks through the synchroniser before a group can report it.
  assumes a 125 MHz clock; the watchdog default spans four bus cycles.
*/
`timescale 1ns/1ns

// Operation
// - sixteen inputs form four groups of four; one group reported as four bits
// - at most one group active; others never reach the reported bits
// - output image may lag master by up to three bus cycles, 15 ms
// - input image transfer to master may take up to three bus cycles
// - bits reported in the cycle a new selection takes effect are invalid
// - one two-colour indicator shows bus status and fault status
module migs_top
  import migs_pkg::*;
#(
  parameter int unsigned WATCHDOG_CYC = BUS_CYCLE_CYC * (LAG_CYCLES + 1)
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [migs_pkg::INPUTS-1:0] inputs_i,
  input  wire logic                      xfer_i,
  input  wire logic                      xfer_ok_i,
  input  wire logic [migs_pkg::GROUP_W-1:0] out_data_i,
  output logic      [migs_pkg::GROUP_W-1:0] in_data_o,
  output logic                           in_valid_o,
  output logic      [migs_pkg::GROUP_W-1:0] group_sel_o,
  output logic                           sel_error_o,
  output logic      [1:0]                led_o
);
  import migs_pkg::*;

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  logic [INPUTS-1:0] inputs_s;

  // all groups are synchronised, not only the active one, so a switchover
  // never starts from stale stages
  migs_sync #(.W(INPUTS)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (inputs_i),
    .sync_o  (inputs_s)
  );

  // ****************************************************************
  // group selection and readout
  // ****************************************************************
  migs_state_t               state_reg,   state_next;
  logic [GROUP_W-1:0]        sel_reg,     sel_next;
  logic [GROUP_W-1:0]        data_reg,    data_next;
  logic                      valid_reg,   valid_next;
  logic                      err_reg,     err_next;
  logic [GROUP_W-1:0]        mux_data;
  logic                      onehot;

  // ****************************************************************
  // selection decode
  // ****************************************************************
  // one-hot check of the received selection
  always_comb begin
    onehot = (out_data_i != SEL_NONE) && ((out_data_i & (out_data_i - 4'h1)) == SEL_NONE);
  end

  // ****************************************************************
  // group multiplexer
  // ****************************************************************
  // only the single selected group reaches the data path
  // driven by the applied selection, so a faulty exchange cannot switch groups
  always_comb begin
    mux_data = DATA_ZERO;
    for (int g = 0; g < GROUPS; g++) begin
      if (sel_reg[g]) begin
        mux_data = inputs_s[g*GROUP_W +: GROUP_W];
      end
    end
  end

  // ****************************************************************
  // exchange state machine
  // ****************************************************************
  // idle holds no group, so a clean exchange with a one-hot word always leaves it as a new selection
  always_comb begin
    state_next = state_reg;
    sel_next   = sel_reg;
    data_next  = data_reg;
    valid_next = valid_reg;
    err_next   = err_reg;
    if (xfer_i && xfer_ok_i) begin
      // a new group answers zero data for one exchange while its inputs
      // are switched over; a word that is not one-hot drops the group
      if (onehot && out_data_i != sel_reg) begin
        sel_next   = out_data_i;
        state_next = MIGS_SETTLE;
        valid_next = 1'b0;
        data_next  = DATA_ZERO;
        err_next   = 1'b0;
      end else if (!onehot) begin
        err_next   = 1'b1;
        valid_next = 1'b0;
        data_next  = DATA_ZERO;
        state_next = MIGS_IDLE;
        sel_next   = SEL_NONE;
      end else begin
        unique case (state_reg)
          MIGS_IDLE: begin
            state_next = MIGS_SETTLE;
            valid_next = 1'b0;
          end
          MIGS_SETTLE: begin
            state_next = MIGS_VALID;
            data_next  = mux_data;
            valid_next = 1'b1;
          end
          MIGS_VALID: begin
            data_next  = mux_data;
            valid_next = 1'b1;
          end
        endcase
        err_next = 1'b0;
      end
    end
  end

  // ****************************************************************
  // exchange registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= MIGS_IDLE;
      sel_reg   <= SEL_NONE;
      data_reg  <= DATA_ZERO;
      valid_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg   <= sel_next;
      data_reg  <= data_next;
      valid_reg <= valid_next;
      err_reg   <= err_next;
    end
  end

  // ****************************************************************
  // bus watchdog
  // ****************************************************************
  localparam int unsigned WD_W = $clog2(WATCHDOG_CYC + 1);

  logic [WD_W-1:0] wd_reg, wd_next;
  logic            bus_ok_reg, bus_ok_next;
  logic [1:0]      led_reg, led_next;

  // only a clean exchange restarts the count; faulty ones prove nothing
  always_comb begin
    wd_next     = wd_reg;
    bus_ok_next = bus_ok_reg;
    if (xfer_i && xfer_ok_i) begin
      wd_next     = '0;
      bus_ok_next = 1'b1;
    end else if (wd_reg >= WD_W'(WATCHDOG_CYC - 1)) begin
      bus_ok_next = 1'b0;
    end else begin
      wd_next = wd_reg + WD_W'(1);
    end
  end

  // ****************************************************************
  // watchdog registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_reg     <= '0;
      bus_ok_reg <= 1'b0;
    end else begin
      wd_reg     <= wd_next;
      bus_ok_reg <= bus_ok_next;
    end
  end

  // ****************************************************************
  // indicator
  // ****************************************************************
  // green for healthy exchange, red for lost bus, both for a refused selection
  always_comb begin
    if (!bus_ok_reg) begin
      led_next = IND_RED;
    end else if (err_reg) begin
      led_next = IND_RED | IND_GREEN;
    end else begin
      led_next = IND_GREEN;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_reg <= IND_OFF;
    end else begin
      led_reg <= led_next;
    end
  end

  // ****************************************************************
  // output ports
  // ****************************************************************
  assign in_data_o   = data_reg;
  assign in_valid_o  = valid_reg;
  assign group_sel_o = sel_reg;
  assign sel_error_o = err_reg;
  assign led_o       = led_reg;
endmodule // migs_top

// *** rtl/migs_pkg.sv ***
/*
  constants for the multiplexed input group slave: group count, widths,
  selection codes, indicator codes and bus-cycle timing.
  assumes a 125 MHz system clock.
*/
package migs_pkg;
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned GROUPS         = 4;
  localparam int unsigned GROUP_W        = 4;
  localparam int unsigned INPUTS         = GROUPS * GROUP_W;
  localparam int unsigned BUS_CYCLE_MS   = 5;
  localparam int unsigned BUS_CYCLE_CYC  = (CLK_HZ / 1000) * BUS_CYCLE_MS;
  localparam int unsigned LAG_CYCLES     = 3;
  localparam int unsigned LAG_MS         = 15;
  localparam int unsigned SWITCH_CYCLES  = 1;
  localparam logic [3:0]  SEL_NONE       = 4'h0;
  localparam logic [3:0]  DATA_ZERO      = 4'h0;
  localparam logic [1:0]  IND_OFF        = 2'h0;
  localparam logic [1:0]  IND_GREEN      = 2'h1;
  localparam logic [1:0]  IND_RED        = 2'h2;
  typedef enum logic [1:0] {MIGS_IDLE, MIGS_SETTLE, MIGS_VALID} migs_state_t;
endpackage

// *** rtl/migs_sync.sv ***
/*
  three-stage input synchroniser; a change is accepted when stages two and
  three agree.
  assumes inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ns
module migs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [W-1:0] out_next;

  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= async_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_o = out_reg;
endmodule // migs_sync

// *** bench/migs_props.sv ***
/* assertions on migs_top ports.
   assumes a bind to migs_top, one clock. */
`timescale 1ns/1ns
module migs_props
  import migs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        xfer_i,
  input wire logic        xfer_ok_i,
  input wire logic [3:0]  out_data_i,
  input wire logic [3:0]  in_data_o,
  input wire logic        in_valid_o,
  input wire logic [3:0]  group_sel_o,
  input wire logic        sel_error_o,
  input wire logic [1:0]  led_o
);
  // ****
  // checks
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence acc_s;
    xfer_i && xfer_ok_i;
  endsequence
  a_invalid_data_zero: assert property (!in_valid_o |-> in_data_o == DATA_ZERO)
    else $error("data not zero while invalid");
  a_one_group: assert property (in_valid_o |-> $onehot(group_sel_o))
    else $error("valid without single group");
  a_sel_code: assert property ($onehot0(group_sel_o))
    else $error("selection not one-hot");
  a_new_sel_invalid: assert property (acc_s ##0 ($onehot(out_data_i) && out_data_i != group_sel_o)
    |=> group_sel_o == $past(out_data_i) && !in_valid_o) else $error("switchover not invalid");
  a_same_sel_valid: assert property (acc_s ##0 ($onehot(out_data_i) && out_data_i == group_sel_o)
    |=> in_valid_o) else $error("repeat selection not valid");
  a_bad_sel_refused: assert property (acc_s ##0 !$onehot(out_data_i)
    |=> sel_error_o && group_sel_o == SEL_NONE && !in_valid_o) else $error("bad selection kept");
  a_hold_faulty: assert property (!(xfer_i && xfer_ok_i)
    |=> $stable(group_sel_o) && $stable(in_valid_o) && $stable(in_data_o)) else $error("state moved");
  a_led_bus_ok: assert property (acc_s ##0 $onehot(out_data_i) ##1 !xfer_i
    |=> led_o == IND_GREEN) else $error("indicator not green");
  a_led_fault_both: assert property (acc_s ##0 !$onehot(out_data_i) ##1 !xfer_i
    |=> led_o == (IND_RED | IND_GREEN)) else $error("indicator not showing fault");
endmodule // migs_props
bind migs_top migs_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .xfer_i(xfer_i), .xfer_ok_i(xfer_ok_i),
  .out_data_i(out_data_i), .in_data_o(in_data_o), .in_valid_o(in_valid_o), .group_sel_o(group_sel_o),
  .sel_error_o(sel_error_o), .led_o(led_o));

// *** bench/migs_master_model.sv ***
/* bus master model issuing one exchange per call and keeping the master's
   copy of the slave input image and its configuration error flag.
   assumes calls from the bench; drives and samples at falling edge. */
`timescale 1ns/1ns
module migs_master_model
  import migs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [3:0]  in_data_i,
  input  wire logic        in_valid_i,
  input  wire logic [3:0]  group_sel_i,
  output logic             xfer_o,
  output logic             xfer_ok_o,
  output logic [3:0]       out_data_o,
  output logic [15:0]      image_o,
  output logic             cfg_err_o
);
  int fails = 0;
  initial begin
    xfer_o = 1'b0;
    xfer_ok_o = 1'b0;
    out_data_o = 4'h0;
    image_o = 16'h0;
    cfg_err_o = 1'b0;
  end
  task automatic exchange(input logic [3:0] sel, input logic ok);
    @(negedge clk_i);
    xfer_o = 1'b1;
    xfer_ok_o = ok;
    out_data_o = sel;
    @(negedge clk_i);
    xfer_o = 1'b0;
    xfer_ok_o = ~ok;
    out_data_o = ~sel; // released word never repeats the last one
    fails = ok ? 0 : fails + 1;
    cfg_err_o = (fails > LAG_CYCLES);
    if (cfg_err_o) begin
      image_o = 16'h0;
    end else if (ok && in_valid_i && group_sel_i == sel) begin
      for (int g = 0; g < GROUPS; g++) begin
        if (sel[g]) begin
          image_o[GROUP_W*g +: GROUP_W] = in_data_i;
        end
      end
    end
  endtask
endmodule // migs_master_model

// *** bench/tb.sv ***
/* testbench for migs_top with master model.
   assumes the small watchdog parameter below. */
`timescale 1ns/1ns
module tb;
  import migs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [15:0] inputs_i = 16'h9c63;
  logic        xfer_i, xfer_ok_i, in_valid_o, sel_error_o;
  logic [3:0]  out_data_i, in_data_o, group_sel_o;
  logic [1:0]  led_o;
  logic [15:0] image;
  logic        cfg_err;
  int          mismatches = 0;
  int          checks_done = 0;
  always #4 clk_i = ~clk_i;
  migs_master_model m (.clk_i(clk_i), .in_data_i(in_data_o), .in_valid_i(in_valid_o), .group_sel_i(group_sel_o),
    .xfer_o(xfer_i), .xfer_ok_o(xfer_ok_i), .out_data_o(out_data_i), .image_o(image), .cfg_err_o(cfg_err));
  migs_top #(.WATCHDOG_CYC(50)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .inputs_i(inputs_i), .xfer_i(xfer_i),
    .xfer_ok_i(xfer_ok_i), .out_data_i(out_data_i), .in_data_o(in_data_o), .in_valid_o(in_valid_o),
    .group_sel_o(group_sel_o), .sel_error_o(sel_error_o), .led_o(led_o));
  // ****
  // scenarios
  // ****
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_groups;
    repeat (8) @(negedge clk_i);
    for (int g = 0; g < 4; g++) begin
      m.exchange(4'h1 << g, 1'b1);
      cmp(group_sel_o, 4'h1 << g);
      cmp({3'h0, in_valid_o}, 4'h0);
      cmp(in_data_o, DATA_ZERO);
      m.exchange(4'h1 << g, 1'b1);
      cmp({3'h0, in_valid_o}, 4'h1);
      cmp(in_data_o, inputs_i[4*g +: 4]);
    end
  endtask
  task automatic t_faulty;
    repeat (3) m.exchange(4'h2, 1'b0);
    cmp(group_sel_o, 4'h8);
    cmp(in_data_o, 4'h9);
    cmp({3'h0, cfg_err}, 4'h0);
    cmp(image[15:12], 4'h9);
    m.exchange(4'h2, 1'b1);
    cmp(group_sel_o, 4'h2);
  endtask
  task automatic t_bad_sel;
    m.exchange(4'h3, 1'b1);
    cmp({3'h0, sel_error_o}, 4'h1);
    cmp(group_sel_o, SEL_NONE);
    @(negedge clk_i);
    cmp({2'h0, led_o}, {2'h0, IND_RED | IND_GREEN});
    m.exchange(4'h4, 1'b1);
    m.exchange(4'h4, 1'b1);
    cmp(in_data_o, 4'hc);
  endtask
  task automatic t_indicator;
    repeat (60) @(negedge clk_i);
    cmp({2'h0, led_o}, {2'h0, IND_RED});
    m.exchange(4'h1, 1'b1);
    @(negedge clk_i);
    cmp({2'h0, led_o}, {2'h0, IND_GREEN});
  endtask
  task automatic t_image;
    inputs_i = 16'h5a3c;
    repeat (6) @(negedge clk_i);
    for (int g = 0; g < GROUPS; g++) begin
      m.exchange(4'h1 << g, 1'b1);
      m.exchange(4'h1 << g, 1'b1);
    end
    @(negedge clk_i);
    for (int g = 0; g < GROUPS; g++) begin
      cmp(image[4*g +: 4], inputs_i[4*g +: 4]);
    end
    repeat (30 / BUS_CYCLE_MS) m.exchange(4'h8, 1'b1);
    cmp(in_data_o, inputs_i[15:12]);
  endtask
  task automatic t_cfg_err;
    repeat (LAG_CYCLES) m.exchange(4'h1, 1'b0);
    cmp({3'h0, cfg_err}, 4'h0);
    cmp(group_sel_o, 4'h8);
    m.exchange(4'h1, 1'b0);
    cmp({3'h0, cfg_err}, 4'h1);
    cmp(image[3:0], DATA_ZERO);
    cmp(image[15:12], DATA_ZERO);
    m.exchange(4'h8, 1'b1);
    cmp({3'h0, cfg_err}, 4'h0);
  endtask
  task automatic t_reset;
    rst_n_i = 1'b0;
    @(negedge clk_i);
    cmp(group_sel_o, SEL_NONE);
    cmp({2'h0, led_o}, {2'h0, IND_OFF});
    rst_n_i = 1'b1;
    @(negedge clk_i);
    cmp({2'h0, led_o}, {2'h0, IND_RED});
    cmp({3'h0, in_valid_o}, 4'h0);
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    cmp({2'h0, led_o}, {2'h0, IND_RED});
    cmp(group_sel_o, SEL_NONE);
    t_groups();
    t_faulty();
    t_bad_sel();
    t_indicator();
    t_image();
    t_cfg_err();
    t_reset();
    report_and_stop();
  end
endmodule // tb
